/* File: rtl/uart_sfb_pkg.sv */
// Constants, field layouts and state encoding of the two-channel serial block
// Contract
// R1: Any status write clears all flags
// R2: Framing flag from start/stop, each reception
// R3: Error flags zero in transmit mode
// R4: Overrun when unread character gets replaced
// R5: Unread state survives enable toggling
// R6: Software reads buffer after every character
// R7: Parity flag from mismatch, each character
// R8: Full set by write, cleared on load
// R9: Full flag zero in receive mode
// R10: Software waits full low before writing
// R11: Frame is start, data, parity, stop
// R12: Data length five to eight bits
// R13: One/two stops, LSB/MSB first selectable
// R14: Line polarity positive or inverted
// R15: Baud counter counts selected clock
// R16: Twelve-bit count, period equals count plus one
// R17: Receive mode drives transmit pin high
// R18: Length code 00=8 to 11=5
// R19: Parity code even, odd, none
// R20: Single selects reset to zero
// R21: Clock select 00 low, 1x high
// R22: Status bits 7..4 read zero
// R23: Two identical independent channels
package uart_sfb_pkg;

	// ==========================================================
	// Register map: word index = byte address / 4
	localparam int          CH_COUNT    = 2;
	localparam logic [11:0] REG_PAGE    = 12'hF29;
	localparam logic [2:0]  OFF_BUF     = 3'h0;
	localparam logic [2:0]  OFF_CON     = 3'h1;
	localparam logic [2:0]  OFF_MOD0    = 3'h2;
	localparam logic [2:0]  OFF_MOD1    = 3'h3;
	localparam logic [2:0]  OFF_BRTL    = 3'h4;
	localparam logic [2:0]  OFF_BRTH    = 3'h5;
	localparam logic [2:0]  OFF_STAT    = 3'h6;
	localparam logic [15:0] STAT0_IDX   = 16'hF296;
	localparam logic [15:0] STAT1_IDX   = 16'hF29E;

	// ==========================================================
	// Field positions
	localparam int CON_EN      = 0;
	localparam int MOD0_IO     = 0;
	localparam int MOD0_CK_HI  = 2;
	localparam int MOD1_LG_LSB = 0;
	localparam int MOD1_PT_ODD = 2;
	localparam int MOD1_PT_OFF = 3;
	localparam int MOD1_STP    = 4;
	localparam int MOD1_NEG    = 5;
	localparam int MOD1_DIR    = 6;
	localparam int STAT_FER    = 0;
	localparam int STAT_OER    = 1;
	localparam int STAT_PER    = 2;
	localparam int STAT_FUL    = 3;

	// ==========================================================
	// Write masks and reset values
	localparam logic [7:0]  MOD0_MASK   = 8'h37;
	localparam logic [7:0]  MOD1_MASK   = 8'h7F;
	localparam logic [3:0]  BRTH_MASK   = 4'hF;
	localparam logic [7:0]  MODE_RESET  = 8'h00;
	localparam logic [11:0] BRT_RESET   = 12'hFFF;
	localparam logic [7:0]  BUF_RESET   = 8'h00;

	// ==========================================================
	// Clock dividers for the baud clock sources
	localparam int LS_DIV_DEFAULT = 3815;
	localparam int HS_DIV_DEFAULT = 1;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_START  = 5'h02,
		ST_DATA   = 5'h04,
		ST_PARITY = 5'h08,
		ST_STOP   = 5'h10
	} line_state_type;

endpackage

/* File: rtl/uart_baud_gen.sv */
// Baud rate generator: one period per count+1 selected clock pulses
`timescale 1ns/1ns
module uart_baud_gen #(
	parameter int CNT_W = 12
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rstn,
	// Control
	input  wire logic             i_run,
	input  wire logic             i_restart,
	input  wire logic             i_clk_en,
	input  wire logic [CNT_W-1:0] i_count,
	// Period events
	output logic                  o_tick,
	output logic                  o_mid
);

	logic [CNT_W-1:0] cnt_reg;

	// R15: counts the selected clock only
	assign o_tick = i_run && !i_restart && i_clk_en && (cnt_reg == i_count);
	assign o_mid  = i_run && !i_restart && i_clk_en && (cnt_reg == (i_count >> 1));

	// R16: wraps after count plus one pulses
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_reg <= '0;
		end else if (!i_run || i_restart) begin
			cnt_reg <= '0;
		end else if (i_clk_en) begin
			if (cnt_reg >= i_count)
				cnt_reg <= '0;
			else
				cnt_reg <= cnt_reg + 1'b1;
		end
	end

endmodule // uart_baud_gen

/* File: rtl/uart_status_format_baud.sv */
// Two-channel asynchronous serial unit with AHB-Lite register slave
`timescale 1ns/1ns
module uart_status_format_baud #(
	parameter int LS_DIV = uart_sfb_pkg::LS_DIV_DEFAULT,
	parameter int HS_DIV = uart_sfb_pkg::HS_DIV_DEFAULT
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// AHB-Lite slave
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	// Serial lines
	input  wire logic [1:0]  i_serial_rx_pin,
	output logic      [1:0]  o_serial_tx_pin
);

	localparam int NC = uart_sfb_pkg::CH_COUNT;

	// ==========================================================
	// Helper functions
	function automatic logic [2:0] bit_pos(input logic [2:0] cnt, input logic [2:0] last,
		input logic msb);
		return msb ? 3'(last - cnt) : cnt;
	endfunction

	// R19: even parity bit is xor of data, odd inverts
	function automatic logic calc_parity(input logic [7:0] data, input logic [2:0] last,
		input logic odd);
		logic [7:0] mask;
		mask = 8'hFF >> (3'h7 - last);
		return (^(data & mask)) ^ odd;
	endfunction

	// ==========================================================
	// Registers
	logic [7:0]  mod0_reg   [NC];
	logic [7:0]  mod1_reg   [NC];
	logic [11:0] brt_reg    [NC];
	logic        en_reg     [NC];
	logic [7:0]  txbuf_reg  [NC];
	logic [7:0]  rxbuf_reg  [NC];
	logic        full_reg   [NC];
	logic        fer_reg    [NC];
	logic        oer_reg    [NC];
	logic        per_reg    [NC];
	logic        unread_reg [NC];
	logic [1:0]  rx_meta_reg;
	logic [1:0]  rx_sync_reg;
	logic [1:0]  tx_pin_reg;

	uart_sfb_pkg::line_state_type state_reg [NC];
	logic [2:0]  bitcnt_reg    [NC];
	logic        stopcnt_reg   [NC];
	logic [7:0]  shift_reg     [NC];
	logic        par_bit_reg   [NC];
	logic        start_bad_reg [NC];
	logic        stop_bad_reg  [NC];

	logic [15:0] ls_cnt_reg;
	logic [15:0] hs_cnt_reg;
	logic        ls_en;
	logic        hs_en;

	// Bus data phase
	logic        dp_valid_reg;
	logic        dp_write_reg;
	logic        dp_ch_reg;
	logic [2:0]  dp_off_reg;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  wdata;
	logic [7:0]  rd8;

	// Per-channel combinational terms
	logic        is_rx     [NC];
	logic [2:0]  last      [NC];
	logic        has_par   [NC];
	logic        rx_line   [NC];
	logic        step      [NC];
	logic        load      [NC];
	logic        restart   [NC];
	logic        stop_last [NC];
	logic        rx_done   [NC];
	logic        tx_end    [NC];
	logic        tx_level  [NC];
	logic        clk_sel   [NC];
	logic        tick      [NC];
	logic        mid       [NC];
	logic [15:0] acc_idx;
	logic        acc_hit;

	function automatic logic wr_sel(input int c, input logic [2:0] off);
		return wr_en && (dp_ch_reg == c[0]) && (dp_off_reg == off);
	endfunction

	// ==========================================================
	// Baud clock sources as enable pulses
	assign ls_en = (ls_cnt_reg == 16'(LS_DIV - 1));
	assign hs_en = (hs_cnt_reg == 16'(HS_DIV - 1));

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ls_cnt_reg <= 16'h0000;
			hs_cnt_reg <= 16'h0000;
		end else begin
			ls_cnt_reg <= ls_en ? 16'h0000 : ls_cnt_reg + 16'h0001;
			hs_cnt_reg <= hs_en ? 16'h0000 : hs_cnt_reg + 16'h0001;
		end
	end

	// ==========================================================
	// AHB-Lite address phase capture
	assign acc_idx = i_haddr[17:2];
	assign acc_hit = (i_haddr[31:18] == 14'h0000) && (acc_idx[15:4] == uart_sfb_pkg::REG_PAGE)
		&& (acc_idx[2:0] != 3'h7);
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			dp_valid_reg <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_ch_reg    <= 1'b0;
			dp_off_reg   <= 3'h0;
		end else if (i_hready) begin
			dp_valid_reg <= i_hsel && i_htrans[1] && acc_hit;
			dp_write_reg <= i_hwrite;
			dp_ch_reg    <= acc_idx[3];
			dp_off_reg   <= acc_idx[2:0];
		end
	end

	assign wr_en = dp_valid_reg && dp_write_reg;
	assign rd_en = dp_valid_reg && !dp_write_reg;
	assign wdata = i_hwdata[7:0];

	// ==========================================================
	// Read data mux
	always_comb begin
		case (dp_off_reg)
			uart_sfb_pkg::OFF_BUF:  rd8 = is_rx[dp_ch_reg] ? rxbuf_reg[dp_ch_reg] : txbuf_reg[dp_ch_reg];
			uart_sfb_pkg::OFF_CON:  rd8 = {7'h00, en_reg[dp_ch_reg]};
			uart_sfb_pkg::OFF_MOD0: rd8 = mod0_reg[dp_ch_reg];
			uart_sfb_pkg::OFF_MOD1: rd8 = mod1_reg[dp_ch_reg];
			uart_sfb_pkg::OFF_BRTL: rd8 = brt_reg[dp_ch_reg][7:0];
			uart_sfb_pkg::OFF_BRTH: rd8 = {4'h0, brt_reg[dp_ch_reg][11:8]};
			// R22: upper status bits read zero
			uart_sfb_pkg::OFF_STAT: rd8 = {4'h0, full_reg[dp_ch_reg], per_reg[dp_ch_reg],
				oer_reg[dp_ch_reg], fer_reg[dp_ch_reg]};
			default:                rd8 = 8'h00;
		endcase
		o_hrdata = rd_en ? {24'h000000, rd8} : 32'h00000000;
	end

	// ==========================================================
	// Receive line synchroniser
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_meta_reg <= 2'h3;
			rx_sync_reg <= 2'h3;
		end else begin
			rx_meta_reg <= i_serial_rx_pin;
			rx_sync_reg <= rx_meta_reg;
		end
	end

	// ==========================================================
	// Per-channel decode of format and events
	always_comb begin
		for (int c = 0; c < NC; c++) begin
			is_rx[c]   = mod0_reg[c][uart_sfb_pkg::MOD0_IO];
			// R12: R18: length code gives last bit index
			last[c]    = 3'(3'h7 - mod1_reg[c][uart_sfb_pkg::MOD1_LG_LSB +: 2]);
			has_par[c] = !mod1_reg[c][uart_sfb_pkg::MOD1_PT_OFF];
			// R14: inverted line logic
			rx_line[c] = rx_sync_reg[c] ^ mod1_reg[c][uart_sfb_pkg::MOD1_NEG];
			// R21: 00 low speed, 1x high speed
			clk_sel[c] = mod0_reg[c][uart_sfb_pkg::MOD0_CK_HI] ? hs_en : ls_en;
			step[c]    = is_rx[c] ? mid[c] : tick[c];
			load[c]    = en_reg[c] && !is_rx[c] && (state_reg[c] == uart_sfb_pkg::ST_IDLE)
				&& full_reg[c];
			restart[c] = load[c] || (en_reg[c] && is_rx[c]
				&& (state_reg[c] == uart_sfb_pkg::ST_IDLE) && !rx_line[c]);
			// R13: one or two stop bits
			stop_last[c] = (state_reg[c] == uart_sfb_pkg::ST_STOP) && step[c]
				&& (stopcnt_reg[c] == mod1_reg[c][uart_sfb_pkg::MOD1_STP]);
			rx_done[c] = stop_last[c] && is_rx[c];
			tx_end[c]  = stop_last[c] && !is_rx[c];
			// R11: start, data, parity, stop order
			case (state_reg[c])
				uart_sfb_pkg::ST_START:  tx_level[c] = 1'b0;
				uart_sfb_pkg::ST_DATA:   tx_level[c] = shift_reg[c][bit_pos(bitcnt_reg[c], last[c],
					mod1_reg[c][uart_sfb_pkg::MOD1_DIR])];
				uart_sfb_pkg::ST_PARITY: tx_level[c] = calc_parity(shift_reg[c], last[c],
					mod1_reg[c][uart_sfb_pkg::MOD1_PT_ODD]);
				default:                 tx_level[c] = 1'b1;
			endcase
		end
	end

	// ==========================================================
	// Channel instances of the baud generator
	// R23: identical generator per channel
	for (genvar g = 0; g < NC; g++) begin : g_baud
		uart_baud_gen #(
			.CNT_W (12)
		) u_baud (
			.i_clk     (i_clk),
			.i_rstn    (i_rstn),
			.i_run     (en_reg[g]),
			.i_restart (restart[g]),
			.i_clk_en  (clk_sel[g]),
			.i_count   (brt_reg[g]),
			.o_tick    (tick[g]),
			.o_mid     (mid[g])
		);
	end

	// ==========================================================
	// Software-written configuration
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int c = 0; c < NC; c++) begin
				// R20: selects reset to zero
				mod0_reg[c]  <= uart_sfb_pkg::MODE_RESET;
				mod1_reg[c]  <= uart_sfb_pkg::MODE_RESET;
				brt_reg[c]   <= uart_sfb_pkg::BRT_RESET;
				en_reg[c]    <= 1'b0;
				txbuf_reg[c] <= uart_sfb_pkg::BUF_RESET;
			end
		end else begin
			for (int c = 0; c < NC; c++) begin
				if (wr_sel(c, uart_sfb_pkg::OFF_MOD0))
					mod0_reg[c] <= wdata & uart_sfb_pkg::MOD0_MASK;
				if (wr_sel(c, uart_sfb_pkg::OFF_MOD1))
					mod1_reg[c] <= wdata & uart_sfb_pkg::MOD1_MASK;
				// R16: twelve-bit count from low and high
				if (wr_sel(c, uart_sfb_pkg::OFF_BRTL))
					brt_reg[c][7:0] <= wdata;
				if (wr_sel(c, uart_sfb_pkg::OFF_BRTH))
					brt_reg[c][11:8] <= wdata[3:0] & uart_sfb_pkg::BRTH_MASK;
				if (wr_sel(c, uart_sfb_pkg::OFF_BUF) && !is_rx[c])
					txbuf_reg[c] <= wdata;
				// Transmit stops itself when nothing is queued
				if (wr_sel(c, uart_sfb_pkg::OFF_CON))
					en_reg[c] <= wdata[uart_sfb_pkg::CON_EN];
				else if (tx_end[c] && !full_reg[c] && !wr_sel(c, uart_sfb_pkg::OFF_BUF))
					en_reg[c] <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Frame sequencer, shared by transmit and receive
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int c = 0; c < NC; c++) begin
				state_reg[c]     <= uart_sfb_pkg::ST_IDLE;
				bitcnt_reg[c]    <= 3'h0;
				stopcnt_reg[c]   <= 1'b0;
				shift_reg[c]     <= 8'h00;
				par_bit_reg[c]   <= 1'b0;
				start_bad_reg[c] <= 1'b0;
				stop_bad_reg[c]  <= 1'b0;
			end
		end else begin
			for (int c = 0; c < NC; c++) begin
				if (!en_reg[c]) begin
					state_reg[c] <= uart_sfb_pkg::ST_IDLE;
				end else begin
					case (state_reg[c])
						uart_sfb_pkg::ST_IDLE: begin
							if (load[c])
								shift_reg[c] <= txbuf_reg[c];
							if (restart[c])
								state_reg[c] <= uart_sfb_pkg::ST_START;
						end
						uart_sfb_pkg::ST_START: begin
							if (step[c]) begin
								if (is_rx[c])
									shift_reg[c] <= 8'h00;
								start_bad_reg[c] <= is_rx[c] && rx_line[c];
								stop_bad_reg[c]  <= 1'b0;
								bitcnt_reg[c]    <= 3'h0;
								state_reg[c]     <= uart_sfb_pkg::ST_DATA;
							end
						end
						uart_sfb_pkg::ST_DATA: begin
							if (step[c]) begin
								// R13: bit order select
								if (is_rx[c])
									shift_reg[c][bit_pos(bitcnt_reg[c], last[c],
										mod1_reg[c][uart_sfb_pkg::MOD1_DIR])] <= rx_line[c];
								bitcnt_reg[c]  <= bitcnt_reg[c] + 3'h1;
								stopcnt_reg[c] <= 1'b0;
								if (bitcnt_reg[c] == last[c])
									state_reg[c] <= has_par[c] ? uart_sfb_pkg::ST_PARITY
										: uart_sfb_pkg::ST_STOP;
							end
						end
						uart_sfb_pkg::ST_PARITY: begin
							if (step[c]) begin
								par_bit_reg[c] <= rx_line[c];
								state_reg[c]   <= uart_sfb_pkg::ST_STOP;
							end
						end
						uart_sfb_pkg::ST_STOP: begin
							if (step[c]) begin
								stop_bad_reg[c] <= stop_bad_reg[c] || (is_rx[c] && !rx_line[c]);
								stopcnt_reg[c]  <= 1'b1;
								if (stop_last[c])
									state_reg[c] <= uart_sfb_pkg::ST_IDLE;
							end
						end
						default: state_reg[c] <= uart_sfb_pkg::ST_IDLE;
					endcase
				end
			end
		end
	end

	// ==========================================================
	// Status flags and receive buffer
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int c = 0; c < NC; c++) begin
				full_reg[c]   <= 1'b0;
				fer_reg[c]    <= 1'b0;
				oer_reg[c]    <= 1'b0;
				per_reg[c]    <= 1'b0;
				unread_reg[c] <= 1'b0;
				rxbuf_reg[c]  <= uart_sfb_pkg::BUF_RESET;
			end
		end else begin
			for (int c = 0; c < NC; c++) begin
				// R9: full held low in receive mode
				if (is_rx[c])
					full_reg[c] <= 1'b0;
				// R8: set by buffer write, cleared on load
				else if (wr_sel(c, uart_sfb_pkg::OFF_BUF))
					full_reg[c] <= 1'b1;
				else if (load[c])
					full_reg[c] <= 1'b0;
				// R1: any status write clears
				else if (wr_sel(c, uart_sfb_pkg::OFF_STAT))
					full_reg[c] <= 1'b0;

				// R3: errors held low in transmit mode
				if (!is_rx[c]) begin
					fer_reg[c] <= 1'b0;
					oer_reg[c] <= 1'b0;
					per_reg[c] <= 1'b0;
				end else if (rx_done[c]) begin
					// R2: start or stop bit invalid
					fer_reg[c] <= start_bad_reg[c] || stop_bad_reg[c] || !rx_line[c];
					// R7: parity mismatch on each character
					per_reg[c] <= has_par[c] && (par_bit_reg[c] != calc_parity(shift_reg[c],
						last[c], mod1_reg[c][uart_sfb_pkg::MOD1_PT_ODD]));
					// R4: previous character still unread
					oer_reg[c] <= unread_reg[c]
						|| (oer_reg[c] && !wr_sel(c, uart_sfb_pkg::OFF_STAT));
				end else if (wr_sel(c, uart_sfb_pkg::OFF_STAT)) begin
					fer_reg[c] <= 1'b0;
					oer_reg[c] <= 1'b0;
					per_reg[c] <= 1'b0;
				end

				// R5: cleared only by a buffer read
				if (rx_done[c]) begin
					unread_reg[c] <= 1'b1;
					rxbuf_reg[c]  <= shift_reg[c];
				end else if (rd_en && dp_ch_reg == c[0] && dp_off_reg == uart_sfb_pkg::OFF_BUF
					&& is_rx[c]) begin
					unread_reg[c] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Transmit pins
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_pin_reg <= 2'h3;
		end else begin
			for (int c = 0; c < NC; c++) begin
				// R17: receive mode drives high
				if (is_rx[c])
					tx_pin_reg[c] <= 1'b1;
				else
					tx_pin_reg[c] <= tx_level[c] ^ mod1_reg[c][uart_sfb_pkg::MOD1_NEG];
			end
		end
	end

	assign o_serial_tx_pin = tx_pin_reg;

endmodule // uart_status_format_baud

/* File: dv/uart_sfb_assertions.sv */
// Checker of bus answers and line levels at the top ports
`timescale 1ns/1ns
module uart_sfb_checker (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// Bus
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	input  wire logic [31:0] o_hrdata,
	input  wire logic        o_hreadyout,
	input  wire logic        o_hresp,
	// Serial lines
	input  wire logic [1:0]  o_serial_tx_pin
);
	localparam logic [29:0] S0 = 30'(uart_sfb_pkg::STAT0_IDX);
	localparam logic [29:0] S1 = 30'(uart_sfb_pkg::STAT1_IDX);
	localparam logic [29:0] M0 = S0 - 30'(uart_sfb_pkg::OFF_STAT) + 30'(uart_sfb_pkg::OFF_MOD0);
	localparam logic [29:0] M1 = M0 + 30'h8;

	logic        ph_valid_reg;
	logic        ph_write_reg;
	logic [29:0] ph_idx_reg;
	logic [1:0]  mode_rx_reg;

	// ==========================================================
	// Data phase tracking
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ph_valid_reg <= 1'b0;
			ph_write_reg <= 1'b0;
			ph_idx_reg   <= '0;
		end else if (i_hready) begin
			ph_valid_reg <= i_hsel & i_htrans[1];
			ph_write_reg <= i_hwrite;
			ph_idx_reg   <= i_haddr[31:2];
		end
	end

	// Mirror of each channel's receive mode select
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_rx_reg <= 2'b00;
		end else if (ph_valid_reg & ph_write_reg & i_hready) begin
			if (ph_idx_reg == M0) mode_rx_reg[0] <= i_hwdata[0];
			if (ph_idx_reg == M1) mode_rx_reg[1] <= i_hwdata[0];
		end
	end

	wire rd_ph = ph_valid_reg & ~ph_write_reg;
	wire st_rx = rd_ph & ((ph_idx_reg == S0 & mode_rx_reg[0]) | (ph_idx_reg == S1 & mode_rx_reg[1]));
	wire st_tx = rd_ph & ((ph_idx_reg == S0 & ~mode_rx_reg[0]) | (ph_idx_reg == S1 & ~mode_rx_reg[1]));

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	// ==========================================================
	// Properties
	property p_ready_ok;
		i_hsel && i_htrans[1] |=> o_hreadyout && !o_hresp;
	endproperty
	a_ready_ok: assert property (p_ready_ok) else $error("bus answer not ready okay");
	property p_rdata_idle;
		!rd_ph |-> o_hrdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read phase");
	property p_rdata_upper;
		rd_ph |-> o_hrdata[31:8] == 24'h0;
	endproperty
	a_rdata_upper: assert property (p_rdata_upper) else $error("upper read data not zero");
	property p_stat_high;
		st_rx || st_tx |-> o_hrdata[7:4] == 4'h0;
	endproperty
	a_stat_high: assert property (p_stat_high) else $error("status high bits not zero");
	property p_rx_full;
		st_rx |-> !o_hrdata[uart_sfb_pkg::STAT_FUL];
	endproperty
	a_rx_full: assert property (p_rx_full) else $error("full flag set in receive mode");
	property p_tx_err;
		st_tx |-> o_hrdata[2:0] == 3'h0;
	endproperty
	a_tx_err: assert property (p_tx_err) else $error("error flag set in transmit mode");
	property p_rx_pin0;
		mode_rx_reg[0] && $past(mode_rx_reg[0]) |-> o_serial_tx_pin[0];
	endproperty
	a_rx_pin0: assert property (p_rx_pin0) else $error("channel 0 pin low in receive mode");
	property p_rx_pin1;
		mode_rx_reg[1] [*2] |-> o_serial_tx_pin[1];
	endproperty
	a_rx_pin1: assert property (p_rx_pin1) else $error("channel 1 pin low in receive mode");
endmodule // uart_sfb_checker

bind uart_status_format_baud uart_sfb_checker uart_sfb_checker_inst (
	.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
	.i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
	.o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_serial_tx_pin(o_serial_tx_pin));

/* File: dv/serial_peer.sv */
// Remote serial device: sends and decodes frames on both channels
`timescale 1ns/1ns
module serial_peer #(
	parameter int BIT_CYC = 16
) (
	input  wire logic       i_clk,
	input  wire logic [1:0] i_tx,
	output logic      [1:0] o_rx
);
	initial o_rx = 2'b11;

	task automatic idle(input int ch, input logic [7:0] m);
		@(posedge i_clk);
		o_rx[ch] <= ~m[5];
	endtask

	task automatic put(input int ch, input logic [7:0] m, input logic b);
		o_rx[ch] <= b ^ m[5];
		repeat (BIT_CYC) @(posedge i_clk);
	endtask

	task automatic send(input int ch, input logic [7:0] m, d, input logic flip, bad);
		int n;
		logic p;
		n = 8 - int'(m[1:0]);
		p = ^(d & (8'hFF >> m[1:0])) ^ m[2] ^ flip;
		@(posedge i_clk);
		put(ch, m, 1'b0);
		for (int i = 0; i < n; i++) put(ch, m, m[6] ? d[n-1-i] : d[i]);
		if (!m[3]) put(ch, m, p);
		put(ch, m, ~bad);
		if (m[4]) put(ch, m, 1'b1);
		o_rx[ch] <= ~m[5];
	endtask

	task automatic recv(input int ch, input logic [7:0] m, output logic [7:0] d, output logic ok);
		int n;
		logic b;
		n = 8 - int'(m[1:0]);
		d = 8'h00;
		while (i_tx[ch] !== m[5]) @(posedge i_clk);
		repeat (BIT_CYC / 2) @(posedge i_clk);
		ok = (i_tx[ch] === m[5]);
		for (int i = 0; i < n; i++) begin
			repeat (BIT_CYC) @(posedge i_clk);
			b = i_tx[ch] ^ m[5];
			if (m[6]) d[n-1-i] = b;
			else d[i] = b;
		end
		if (!m[3]) begin
			repeat (BIT_CYC) @(posedge i_clk);
			ok = ok & ((i_tx[ch] ^ m[5]) === (^d ^ m[2]));
		end
		for (int i = 0; i <= int'(m[4]); i++) begin
			repeat (BIT_CYC) @(posedge i_clk);
			ok = ok & ((i_tx[ch] ^ m[5]) === 1'b1);
		end
	endtask

	task automatic width(input int ch, output int w);
		while (i_tx[ch] !== 1'b0) @(posedge i_clk);
		w = 0;
		while (i_tx[ch] === 1'b0) begin
			w++;
			@(posedge i_clk);
		end
	endtask
endmodule // serial_peer

/* File: dv/tb.sv */
// Register level testbench of the two-channel serial block
`timescale 1ns/1ns
module tb;
	localparam int LS = 2;
	localparam int HS = 1;
	localparam int BP = 16;
	localparam logic [2:0] OB = uart_sfb_pkg::OFF_BUF, OC = uart_sfb_pkg::OFF_CON, OS = uart_sfb_pkg::OFF_STAT;
	localparam logic [2:0] OM0 = uart_sfb_pkg::OFF_MOD0, OM1 = uart_sfb_pkg::OFF_MOD1;
	localparam logic [2:0] OBL = uart_sfb_pkg::OFF_BRTL, OBH = uart_sfb_pkg::OFF_BRTH;

	logic        clk    = 1'b0;
	logic        rstn   = 1'b0;
	logic        hsel   = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] haddr  = 32'h0;
	logic [31:0] hwdata = 32'h0;
	wire  [31:0] hrdata;
	wire         hready;
	wire  [1:0]  rx;
	wire  [1:0]  tx;
	int          errors = 0;
	int          num_checks = 0;
	int          w;
	logic [7:0]  g0, g1;
	logic        ok0, ok1;
	logic [7:0]  rst_v[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h0F, 8'h00};
	logic [7:0]  txm[4]   = '{8'h00, 8'h05, 8'h1A, 8'h63};
	logic [7:0]  txd[4]   = '{8'hA5, 8'h3C, 8'h96, 8'h4E};
	logic [7:0]  rxm[5]   = '{8'h00, 8'h00, 8'h00, 8'h35, 8'h4B};
	logic [7:0]  rxd[5]   = '{8'hA5, 8'h5A, 8'hC3, 8'h6E, 8'h1D};
	logic        rxf[5]   = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
	logic        rxb[5]   = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	logic [7:0]  rxs[5]   = '{8'h00, 8'h04, 8'h01, 8'h00, 8'h00};

	always #4 clk = ~clk;

	uart_status_format_baud #(.LS_DIV(LS), .HS_DIV(HS)) uart_status_format_baud_inst (
		.i_clk(clk), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
		.i_serial_rx_pin(rx), .o_serial_tx_pin(tx));
	serial_peer #(.BIT_CYC(BP)) serial_peer_inst (.i_clk(clk), .i_tx(tx), .o_rx(rx));

	// ==========================================================
	// Bus and compare tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [15:0] ix(input int ch, input logic [2:0] off);
		return 16'hF290 + 16'(8 * ch) + 16'(off);
	endfunction

	task automatic ahb(input logic wr, input logic [15:0] idx, input logic [7:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr  <= {14'h0, idx, 2'b00};
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input int ch, input logic [2:0] off, input logic [7:0] d);
		logic [31:0] q;
		ahb(1'b1, ix(ch, off), d, q);
	endtask

	task automatic rdc(input int ch, input logic [2:0] off, input logic [7:0] e);
		logic [31:0] q;
		ahb(1'b0, ix(ch, off), 8'h00, q);
		chk(q, {24'h0, e});
	endtask

	task automatic wait_empty(input int ch);
		logic [31:0] q;
		do ahb(1'b0, ix(ch, OS), 8'h00, q); while (q[3] !== 1'b0);
	endtask

	task automatic tally_and_finish;
		if (errors == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		tally_and_finish();
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		for (int c = 0; c < 2; c++)
			for (int o = 0; o < 7; o++) rdc(c, 3'(o), rst_v[o]);
		wr(1, 3'h7, 8'hFF);
		rdc(1, 3'h7, 8'h00);
		wr(1, OM0, 8'hFF);
		rdc(1, OM0, 8'h37);
		wr(1, OM1, 8'hFF);
		rdc(1, OM1, 8'h7F);
		wr(1, OBH, 8'hFF);
		rdc(1, OBH, 8'h0F);
		wr(1, OS, 8'hFF);
		rdc(1, OS, 8'h00);
		wr(1, OM0, 8'h00);
		wr(1, OM1, 8'h00);
		// Bit period from each clock select, on the parity bit
		for (int k = 0; k < 2; k++) begin
			wr(0, OM0, k ? 8'h04 : 8'h00);
			wr(0, OBL, k ? 8'h0F : 8'h03);
			wr(0, OBH, 8'h00);
			wr(0, OC, 8'h01);
			wr(0, OB, 8'hFF);
			serial_peer_inst.width(0, w);
			serial_peer_inst.width(0, w);
			chk(32'(w), k ? 32'(16 * HS) : 32'(4 * LS));
			repeat (12 * BP) @(posedge clk);
			rdc(0, OC, 8'h00);
		end
		// Transmit formats, two frames back to back
		for (int i = 0; i < 4; i++) begin
			wr(0, OM1, txm[i]);
			repeat (4) @(posedge clk);
			fork
				begin
					serial_peer_inst.recv(0, txm[i], g0, ok0);
					serial_peer_inst.recv(0, txm[i], g1, ok1);
				end
				begin
					wr(0, OC, 8'h01);
					wr(0, OB, txd[i]);
					wait_empty(0);
					wr(0, OB, ~txd[i]);
					rdc(0, OS, 8'h08);
					wait_empty(0);
				end
			join
			chk({24'h0, g0}, {24'h0, txd[i] & (8'hFF >> txm[i][1:0])});
			chk({31'h0, ok0}, 32'h1);
			chk({24'h0, g1}, {24'h0, ~txd[i] & (8'hFF >> txm[i][1:0])});
			chk({31'h0, ok1}, 32'h1);
			repeat (2 * BP) @(posedge clk);
			rdc(0, OC, 8'h00);
		end
		// Reception with the parity and framing flags on channel 1
		wr(1, OM0, 8'h05);
		wr(1, OBL, 8'h0F);
		wr(1, OBH, 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(1, OC, 8'h00);
			wr(1, OM1, rxm[i]);
			serial_peer_inst.idle(1, rxm[i]);
			wr(1, OC, 8'h01);
			serial_peer_inst.send(1, rxm[i], rxd[i], rxf[i], rxb[i]);
			wr(1, OB, 8'h55);
			rdc(1, OS, rxs[i]);
			rdc(1, OB, rxd[i] & (8'hFF >> rxm[i][1:0]));
			wr(1, OS, 8'h00);
			rdc(1, OS, 8'h00);
		end
		// Unread character kept across enable toggle
		serial_peer_inst.send(1, rxm[4], 8'h11, 1'b0, 1'b0);
		wr(1, OC, 8'h00);
		wr(1, OC, 8'h01);
		serial_peer_inst.send(1, rxm[4], 8'h12, 1'b0, 1'b0);
		rdc(1, OS, 8'h02);
		rdc(1, OB, 8'h12);
		wr(1, OS, 8'h00);
		serial_peer_inst.send(1, rxm[4], 8'h13, 1'b0, 1'b0);
		rdc(1, OS, 8'h00);
		rdc(1, OB, 8'h13);
		tally_and_finish();
	end
endmodule // tb
